// ===== hw/acs_cfg.svh
`ifndef ACS_CFG_SVH
`define ACS_CFG_SVH
// Serial frame geometry, counted in serial clock falling edges from zero.
`define ACS_WORD_BITS      16
`define ACS_CTRL_BITS      12
`define ACS_EDGE_FIRST     5'h00
`define ACS_EDGE_CTRL      5'h0B
`define ACS_EDGE_LAST      5'h0F
`define ACS_EDGE_DONE      5'h10
`define ACS_EDGE_SAR_FIRST 5'h01
`define ACS_EDGE_SAR_LAST  5'h0C
// Control word bit positions, bit 11 is the first bit received.
`define ACS_BIT_WRITE      11
`define ACS_BIT_SEQUENCE_ENABLE 10
`define ACS_BIT_CHAN_MSB   9
`define ACS_BIT_CHAN_LSB   6
`define ACS_BIT_PM_MSB     5
`define ACS_BIT_PM_LSB     4
`define ACS_BIT_PATTERN_SELECT 3
`define ACS_BIT_WEAK       2
`define ACS_BIT_RANGE      1
`define ACS_BIT_CODING     0
// Reset values of the control fields and the channel pattern.
`define ACS_RST_CHAN       4'h0
`define ACS_RST_PM         2'h0
`define ACS_RST_WEAK       1'h0
`define ACS_RST_RANGE      1'h0
`define ACS_RST_CODING     1'h0
`define ACS_RST_PATTERN    16'h0000
// Conversion code handling.
`define ACS_SAR_MSB_TRIAL  12'h800
`define ACS_TWOS_FLIP      12'h800
`endif

// ===== hw/acs_pkg.sv
package acs_pkg;

   // Sequencer modes; arm turns to load on the last edge of the arming frame, so the next frame is the pattern frame.
   typedef enum logic [2:0] {
      ACS_MODE_SINGLE,
      ACS_MODE_ARM,
      ACS_MODE_LOAD,
      ACS_MODE_PATTERN,
      ACS_MODE_CONSEC
   } acs_mode_t;

   // Control fields kept from the last accepted write.
   typedef struct packed {
      logic [3:0] chan_sel;
      logic [1:0] power_mode;
      logic       weak_tri;
      logic       range_one_ref;
      logic       straight_binary;
   } acs_ctrl_t;

   // One finished conversion with the mode and control fields as they stand at its last edge.
   typedef struct packed {
      logic [15:0] word;
      acs_mode_t   mode;
      acs_ctrl_t   ctrl;
   } acs_result_t;

endpackage : acs_pkg

// ===== hw/acs_sync.sv
`timescale 1ns/10ps
`default_nettype none
// Two flip-flop synchroniser; only the second stage may be read.
module acs_sync #(
   parameter int WIDTH = 1
) (
   // Destination clock and reset.
   input  wire logic             clk_i,
   input  wire logic             rst_i,
   // Asynchronous level in, synchronised level out.
   input  wire logic [WIDTH-1:0] async_i,
   output logic      [WIDTH-1:0] sync_o
);

   logic [WIDTH-1:0] meta_ff;  // First stage, may go metastable.
   logic [WIDTH-1:0] sync_ff;  // Second stage, safe to use.

   // Both stages clear on reset so the output is defined at once.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         meta_ff <= '0;
         sync_ff <= '0;
      end else begin
         meta_ff <= async_i;
         sync_ff <= meta_ff;
      end
   end

   assign sync_o = sync_ff;

endmodule : acs_sync
`default_nettype wire

// ===== hw/acs_sar.sv
`timescale 1ns/10ps
`default_nettype none
`include "acs_cfg.svh"
// Successive approximation register stepped by the serial clock.
module acs_sar
   import acs_pkg::*;
(
   // Serial clock and reset; reset also ends each frame.
   input  wire logic        sclk_i,
   input  wire logic        rst_i,
   // Edge index within the frame and comparator decision.
   input  wire logic [4:0]  edge_i,
   input  wire logic        comp_i,
   // Trial code to the DAC and the decided code.
   output logic      [11:0] dac_code_o,
   output logic      [11:0] code_o
);

   logic [11:0] dac_ff;   // Current trial code.
   logic [11:0] code_ff;  // Bits decided so far.
   logic [11:0] mask;     // Bit under trial on this edge.
   logic [11:0] kept;     // Decided code including this edge.

   // The bit under trial walks from the MSB, one per edge.
   always_comb begin
      mask = `ACS_SAR_MSB_TRIAL >> 4'(edge_i - `ACS_EDGE_SAR_FIRST);
      kept = comp_i ? code_ff | mask : code_ff;
   end

   // One decision per falling edge; the next trial adds the next lower bit.
   always_ff @(negedge sclk_i or posedge rst_i) begin
      if (rst_i) begin
         dac_ff  <= `ACS_SAR_MSB_TRIAL;
         code_ff <= '0;
      end else if (edge_i >= `ACS_EDGE_SAR_FIRST && edge_i <= `ACS_EDGE_SAR_LAST) begin
         code_ff <= kept;
         dac_ff  <= kept | (mask >> 1);
      end
   end

   assign dac_code_o = dac_ff;
   assign code_o     = code_ff;

endmodule : acs_sar
`default_nettype wire

// ===== hw/acs_top.sv
`timescale 1ns/10ps
`default_nettype none
`include "acs_cfg.svh"
module acs_top
   import acs_pkg::*;
(
   // System clock and reset; synchronous in the system domain, asynchronous for the serial clock registers.
   input  wire logic        clock_i,
   input  wire logic        rst_i,
   // Serial link pins; the serial clock runs only inside frames.
   input  wire logic        sclk_i,
   input  wire logic        cs_n_i,
   input  wire logic        din_i,
   output logic             dout_o,
   output logic             dout_oe_o,
   // Converter core: comparator in, multiplexer and DAC controls out.
   input  wire logic        comp_i,
   output logic      [3:0]  mux_sel_o,
   output logic      [11:0] dac_code_o,
   output logic             span_one_ref_o,
   output logic      [1:0]  power_mode_o,
   // System side results and status.
   output acs_result_t      result_o,
   output logic             result_valid_o,
   output logic             busy_o
);

   ////////////////////////////////////////////////////////////////////////////
   // Link domain declarations; the registers among them are clocked by the serial clock.
   ////////////////////////////////////////////////////////////////////////////
   logic        frame_rst;        // Ends a frame: reset or chip select high.
   logic [4:0]  edge_ff;          // Falling edges seen in this frame.
   logic [14:0] in_shift_ff;      // Serial input bits received so far.
   logic [11:0] ctrl_word;        // Twelve bits complete on the control edge.
   logic [15:0] pattern_word;     // Sixteen bits complete on the last edge.
   logic        at_ctrl;          // This edge completes the control word.
   logic        at_last;          // This edge completes the frame.
   acs_ctrl_t   ctrl_ff;          // Accepted control fields.
   acs_ctrl_t   nxt_ctrl;         // Control fields after this edge.
   acs_mode_t   mode_ff;          // Sequencer mode.
   acs_mode_t   nxt_mode;         // Mode after this edge.
   logic        consec_new_ff;    // Consecutive mode entered in this frame.
   logic [15:0] pattern_ff;       // Channel pattern, bit 15 is channel 0.
   logic [3:0]  chan_ff;          // Channel converted in the current frame.
   logic [3:0]  nxt_chan;         // Channel for the next frame.
   logic [11:0] sar_code;         // Decided conversion bits.
   logic [11:0] data_fmt;         // Conversion bits in the selected coding.
   logic        frame_coding_ff;  // Coding in force when this frame began.
   logic [15:0] word_now;         // Output word of the current frame.
   logic        dout_ff;          // Serial output bit.
   acs_result_t result_ff;        // Last finished result, held for the crossing.
   logic        result_tgl_ff;    // Flips once per finished result.
   logic        write_req;        // Control word asks for an update.
   logic        keep_running;     // Write combination that keeps a sequence.

   ////////////////////////////////////////////////////////////////////////////
   // Frame timing.
   ////////////////////////////////////////////////////////////////////////////
   // Chip select high clears the frame at once; the serial clock may be stopped.
   assign frame_rst = rst_i | cs_n_i;

   // Count falling edges; extra edges past the word are ignored.
   always_ff @(negedge sclk_i or posedge frame_rst) begin
      if (frame_rst) begin
         edge_ff <= '0;
      end else if (edge_ff != `ACS_EDGE_DONE) begin
         edge_ff <= edge_ff + 5'h01;
      end
   end

   // Shift the serial input in, first bit received ends up highest.
   always_ff @(negedge sclk_i or posedge frame_rst) begin
      if (frame_rst) begin
         in_shift_ff <= '0;
      end else if (edge_ff != `ACS_EDGE_DONE) begin
         in_shift_ff <= {in_shift_ff[13:0], din_i};
      end
   end

   // The bit on the current edge completes both views of the input word.
   assign ctrl_word    = {in_shift_ff[10:0], din_i};
   assign pattern_word = {in_shift_ff, din_i};
   assign at_ctrl      = (edge_ff == `ACS_EDGE_CTRL);
   assign at_last      = (edge_ff == `ACS_EDGE_LAST);

   // During the pattern frame the input carries channel bits, not control.
   assign write_req    = at_ctrl && ctrl_word[`ACS_BIT_WRITE] && (mode_ff != ACS_MODE_LOAD);
   assign keep_running = ctrl_word[`ACS_BIT_SEQUENCE_ENABLE] && !ctrl_word[`ACS_BIT_PATTERN_SELECT];

   ////////////////////////////////////////////////////////////////////////////
   // Control fields.
   ////////////////////////////////////////////////////////////////////////////
   // Take the fields from the first twelve input bits when the write flag is
   // set; with the flag low the register is left alone.
   always_comb begin
      nxt_ctrl = ctrl_ff;
      if (write_req) begin
         nxt_ctrl.chan_sel        = ctrl_word[`ACS_BIT_CHAN_MSB:`ACS_BIT_CHAN_LSB];
         nxt_ctrl.power_mode      = ctrl_word[`ACS_BIT_PM_MSB:`ACS_BIT_PM_LSB];
         nxt_ctrl.weak_tri        = ctrl_word[`ACS_BIT_WEAK];
         nxt_ctrl.range_one_ref   = ctrl_word[`ACS_BIT_RANGE];
         nxt_ctrl.straight_binary = ctrl_word[`ACS_BIT_CODING];
      end
   end

   // The fields persist across frames, so only the system reset clears them.
   always_ff @(negedge sclk_i or posedge rst_i) begin
      if (rst_i) begin
         ctrl_ff.chan_sel        <= `ACS_RST_CHAN;
         ctrl_ff.power_mode      <= `ACS_RST_PM;
         ctrl_ff.weak_tri        <= `ACS_RST_WEAK;
         ctrl_ff.range_one_ref   <= `ACS_RST_RANGE;
         ctrl_ff.straight_binary <= `ACS_RST_CODING;
      end else begin
         ctrl_ff <= nxt_ctrl;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Sequencer mode.
   ////////////////////////////////////////////////////////////////////////////
   // Writes change the mode on the control edge; the pattern hand-over steps
   // happen on the last edge so that they line up with whole frames.
   always_comb begin
      nxt_mode = mode_ff;
      if (write_req) begin
         if (keep_running) begin
            // A running sequence keeps its mode; while armed it cancels the arming.
            if (mode_ff == ACS_MODE_ARM) begin
               nxt_mode = ACS_MODE_SINGLE;
            end
         end else if (ctrl_word[`ACS_BIT_SEQUENCE_ENABLE]) begin
            nxt_mode = ACS_MODE_CONSEC;
         end else if (ctrl_word[`ACS_BIT_PATTERN_SELECT]) begin
            nxt_mode = ACS_MODE_ARM;
         end else begin
            nxt_mode = ACS_MODE_SINGLE;
         end
      end else if (at_last) begin
         unique case (mode_ff)
            ACS_MODE_ARM: begin
               nxt_mode = ACS_MODE_LOAD;
            end
            ACS_MODE_LOAD: begin
               // An empty pattern has nothing to run, so fall back.
               nxt_mode = (pattern_word == '0) ? ACS_MODE_SINGLE : ACS_MODE_PATTERN;
            end
            ACS_MODE_SINGLE, ACS_MODE_PATTERN, ACS_MODE_CONSEC: begin
               nxt_mode = mode_ff;
            end
         endcase
      end
   end

   // Mode register, cleared only by the system reset.
   always_ff @(negedge sclk_i or posedge rst_i) begin
      if (rst_i) begin
         mode_ff <= ACS_MODE_SINGLE;
      end else begin
         mode_ff <= nxt_mode;
      end
   end

   // Consecutive mode just entered: the next frame starts at channel zero.
   always_ff @(negedge sclk_i or posedge rst_i) begin
      if (rst_i) begin
         consec_new_ff <= 1'b0;
      end else if (write_req && !keep_running) begin
         consec_new_ff <= ctrl_word[`ACS_BIT_SEQUENCE_ENABLE] && ctrl_word[`ACS_BIT_PATTERN_SELECT];
      end else if (at_last) begin
         consec_new_ff <= 1'b0;
      end
   end

   // Pattern loads in the frame after arming; a cut frame keeps the old one.
   always_ff @(negedge sclk_i or posedge rst_i) begin
      if (rst_i) begin
         pattern_ff <= `ACS_RST_PATTERN;
      end else if (at_last && mode_ff == ACS_MODE_LOAD) begin
         pattern_ff <= pattern_word;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Channel selection.
   ////////////////////////////////////////////////////////////////////////////
   // Lowest selected channel at or above floor_ch, else the lowest selected.
   // Channel n sits at pattern bit 15-n. An empty pattern gives channel 0.
   function automatic logic [3:0] acs_pick(input logic [15:0] pat, input logic [4:0] floor_ch);
      logic [3:0] low;
      logic [3:0] above;
      logic       got_above;
      low       = '0;
      above     = '0;
      got_above = 1'b0;
      for (int ch = 15; ch >= 0; ch--) begin
         if (pat[15-ch]) begin
            low = 4'(ch);
            if (5'(ch) >= floor_ch) begin
               above     = 4'(ch);
               got_above = 1'b1;
            end
         end
      end
      return got_above ? above : low;
   endfunction : acs_pick

   // Channel for the next frame, worked out from the mode this frame ends in.
   always_comb begin
      nxt_chan = chan_ff;
      unique case (mode_ff)
         ACS_MODE_SINGLE, ACS_MODE_ARM: begin
            nxt_chan = ctrl_ff.chan_sel;
         end
         ACS_MODE_LOAD: begin
            if (pattern_word == '0) begin
               nxt_chan = ctrl_ff.chan_sel;
            end else begin
               nxt_chan = acs_pick(pattern_word, 5'h00);
            end
         end
         ACS_MODE_PATTERN: begin
            nxt_chan = acs_pick(pattern_ff, {1'b0, chan_ff} + 5'h01);
         end
         ACS_MODE_CONSEC: begin
            // A lowered final channel below the current one also wraps.
            if (consec_new_ff || chan_ff >= ctrl_ff.chan_sel) begin
               nxt_chan = 4'h0;
            end else begin
               nxt_chan = chan_ff + 4'h1;
            end
         end
      endcase
   end

   // Step at the end of each complete frame only; a cut frame does not advance.
   always_ff @(negedge sclk_i or posedge rst_i) begin
      if (rst_i) begin
         chan_ff <= `ACS_RST_CHAN;
      end else if (at_last) begin
         chan_ff <= nxt_chan;
      end
   end

   assign mux_sel_o      = chan_ff;
   assign span_one_ref_o = ctrl_ff.range_one_ref;
   assign power_mode_o   = ctrl_ff.power_mode;

   ////////////////////////////////////////////////////////////////////////////
   // Conversion and output word.
   ////////////////////////////////////////////////////////////////////////////
   // The approximation register runs on the same serial clock edges.
   acs_sar u_sar (
      .sclk_i     (sclk_i),
      .rst_i      (frame_rst),
      .edge_i     (edge_ff),
      .comp_i     (comp_i),
      .dac_code_o (dac_code_o),
      .code_o     (sar_code)
   );

   // A write at the control edge must not change a word already half sent.
   always_ff @(negedge sclk_i or posedge rst_i) begin
      if (rst_i) begin
         frame_coding_ff <= `ACS_RST_CODING;
      end else if (edge_ff == `ACS_EDGE_FIRST) begin
         frame_coding_ff <= ctrl_ff.straight_binary;
      end
   end

   // Twos complement is straight binary with the top bit flipped.
   assign data_fmt = frame_coding_ff ? sar_code : sar_code ^ `ACS_TWOS_FLIP;
   assign word_now = {chan_ff, data_fmt};

   // Each falling edge presents the next word bit; data bits go out two edges
   // after their decision. The last edge preloads the next tag MSB.
   always_ff @(negedge sclk_i or posedge rst_i) begin
      if (rst_i) begin
         dout_ff <= 1'b0;
      end else if (at_last) begin
         dout_ff <= nxt_chan[3];
      end else if (edge_ff < `ACS_EDGE_LAST) begin
         dout_ff <= word_now[4'(`ACS_EDGE_LAST - 5'h01 - edge_ff)];
      end
   end

   assign dout_o = dout_ff;

   // Hold the word for a whole frame, far longer than the toggle crossing.
   always_ff @(negedge sclk_i or posedge rst_i) begin
      if (rst_i) begin
         result_ff     <= '0;
         result_tgl_ff <= 1'b0;
      end else if (at_last) begin
         result_ff.word <= word_now;
         result_ff.mode <= mode_ff;
         result_ff.ctrl <= ctrl_ff;
         result_tgl_ff  <= ~result_tgl_ff;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // System domain.
   ////////////////////////////////////////////////////////////////////////////
   logic        tgl_sync;     // Result toggle in the system domain.
   logic        cs_n_sync;    // Chip select in the system domain.
   logic        tgl_seen_ff;  // Toggle value already handled.
   acs_result_t result_o_ff;  // Result shown to the system.
   logic        valid_ff;     // One-cycle result strobe.
   logic        oe_ff;        // Output drive enable.

   // Event and level crossings share one synchroniser instance.
   acs_sync #(.WIDTH (2)) u_sync (
      .clk_i   (clock_i),
      .rst_i   (rst_i),
      .async_i ({result_tgl_ff, cs_n_i}),
      .sync_o  ({tgl_sync, cs_n_sync})
   );

   // A toggle change means a stable new result; capture it with a strobe.
   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         tgl_seen_ff <= 1'b0;
         result_o_ff <= '0;
         valid_ff    <= 1'b0;
      end else begin
         tgl_seen_ff <= tgl_sync;
         valid_ff    <= tgl_sync != tgl_seen_ff;
         if (tgl_sync != tgl_seen_ff) begin
            result_o_ff <= result_ff;
         end
      end
   end

   // Drive while chip select is low; the three-cycle lag fits in half a bit time.
   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         oe_ff <= 1'b0;
      end else begin
         oe_ff <= ~cs_n_sync;
      end
   end

   assign result_o       = result_o_ff;
   assign result_valid_o = valid_ff;
   assign dout_oe_o      = oe_ff;
   assign busy_o         = oe_ff;

endmodule : acs_top
`default_nettype wire

// ===== hw/placeholder_none.sv
`timescale 1ns/10ps
`default_nettype none
`default_nettype wire

// ===== dv/acs_top_sva.sv
`timescale 1ns/10ps
`default_nettype none
// Port-level checker for the converter control top.
module acs_top_sva
   import acs_pkg::*;
(
   // System clock and reset.
   input wire logic        clock_i,
   input wire logic        rst_i,
   // Serial link.
   input wire logic        sclk_i,
   input wire logic        cs_n_i,
   input wire logic        din_i,
   input wire logic        dout_o,
   input wire logic        dout_oe_o,
   // Converter core and results.
   input wire logic        comp_i,
   input wire logic [3:0]  mux_sel_o,
   input wire logic [11:0] dac_code_o,
   input wire logic        span_one_ref_o,
   input wire logic [1:0]  power_mode_o,
   input wire acs_result_t result_o,
   input wire logic        result_valid_o,
   input wire logic        busy_o
);
   logic [3:0] since_low_ff; // Cycles since chip select was last seen low.

   // Saturating count, so a result can be tied to the frame that made it.
   always_ff @(posedge clock_i) begin
      if (rst_i || !cs_n_i) begin
         since_low_ff <= 4'h0;
      end else if (since_low_ff != 4'hF) begin
         since_low_ff <= since_low_ff + 4'h1;
      end
   end

   default clocking cb @(posedge clock_i); endclocking
   default disable iff (rst_i);

   a_mux_idle_stable:
      assert property (cs_n_i[*7] |-> $stable(mux_sel_o)) else $error("channel moved between frames");
   a_span_idle_stable:
      assert property (cs_n_i[*7] |-> $stable(span_one_ref_o)) else $error("range moved between frames");
   a_sar_idle_code:
      assert property (cs_n_i[*3] |-> dac_code_o == 12'h800) else $error("trial code not parked");
   a_dout_idle_hold:
      assert property (cs_n_i[*2] |-> $stable(dout_o)) else $error("serial output moved when idle");
   a_oe_on_frame:
      assert property ((!cs_n_i)[*5] |-> dout_oe_o) else $error("drive enable late");
   a_oe_off_idle:
      assert property (cs_n_i[*5] |-> !dout_oe_o && !busy_o) else $error("drive enable stuck");
   a_valid_one_cycle:
      assert property (result_valid_o |=> !result_valid_o) else $error("result strobe too long");
   a_result_hold_value:
      assert property ($changed(result_o) |-> result_valid_o) else $error("result changed silently");
   a_valid_after_frame:
      assert property (result_valid_o |-> since_low_ff < 4'h8) else $error("result without a frame");

   c_single: cover property (result_valid_o && result_o.mode == ACS_MODE_SINGLE);
   c_pattern: cover property (result_valid_o && result_o.mode == ACS_MODE_PATTERN);
   c_consec: cover property (result_valid_o && result_o.mode == ACS_MODE_CONSEC);
endmodule : acs_top_sva
bind acs_top acs_top_sva chk (.*);
`default_nettype wire

// ===== dv/acs_host.sv
`timescale 1ns/10ps
`default_nettype none
// Host serial port: 160 ns serial clock, idling high outside frames.
module acs_host (
   // Link pins toward the converter.
   output logic      sclk_o,
   output logic      cs_n_o,
   output logic      din_o,
   input  wire logic dout_i
);
   initial begin
      sclk_o = 1'b1;
      cs_n_o = 1'b1;
      din_o  = 1'b0;
   end

   // One full 16-bit frame; the 3 ns lead keeps edges off the system grid.
   task automatic xfer(input logic [15:0] tx, output logic [15:0] rx);
      #3 cs_n_o = 1'b0;
      #40;
      for (int i = 15; i >= 0; i--) begin
         rx[i] = dout_i;
         din_o = tx[i];
         #40 sclk_o = 1'b0;
         #80 sclk_o = 1'b1;
         #40;
      end
      cs_n_o = 1'b1;
      din_o  = ~din_o; // Released line must not keep its last value.
   endtask : xfer
endmodule : acs_host
`default_nettype wire

// ===== dv/acs_top_bench.sv
`timescale 1ns/10ps
`default_nettype none
module acs_top_bench
   import acs_pkg::*;
;
   logic        clock_i, rst_i, sclk_i, cs_n_i, din_i, comp_i;
   logic        dout_o, dout_oe_o, span_one_ref_o, result_valid_o, busy_o;
   logic [3:0]  mux_sel_o;
   logic [11:0] dac_code_o;
   logic [1:0]  power_mode_o;
   acs_result_t result_o;
   int          mismatches, checks_done, got_n;
   logic [15:0] got; // Last word seen on the system side.
   logic        cod; // Coding in force for the next conversion.

   acs_top dut (.*);
   acs_host host (.sclk_o(sclk_i), .cs_n_o(cs_n_i), .din_o(din_i), .dout_i(dout_o));

   // Each channel holds the level {channel, A5}, so the tag shows in the data.
   assign comp_i = {mux_sel_o, 8'hA5} >= dac_code_o;
   always #4 clock_i = ~clock_i;
   always @(posedge clock_i) if (result_valid_o) begin got <= result_o.word; got_n <= got_n + 1; end

   task end_sim;
      if (mismatches == 0 && checks_done > 0) begin $display("TEST PASSED"); end
      else begin $display("TEST FAILED"); end
      $finish;
   endtask : end_sim

   task check(input logic [15:0] act, input logic [15:0] exp);
      checks_done++;
      if (act !== exp) begin mismatches++; $display("unexpected at %0t: got %h expected %h", $time, act, exp); end
   endtask : check

   function automatic logic [15:0] cw(logic s, logic [3:0] c, logic p, logic r, logic k);
      return {1'b1, s, c, 2'h3, p, 1'b0, r, k, 4'h0};
   endfunction : cw

   // Sends one frame and checks the word on the wire and on the system side.
   task frame(input logic [15:0] tx, input logic [3:0] ch);
      logic [15:0] rx, exp;
      int n;
      n = got_n;
      host.xfer(tx, rx);
      exp = {ch, ch, 8'hA5};
      if (!cod) exp[11] = ~exp[11];
      check(rx, exp);
      for (int i = 0; i < 20 && got_n == n; i++) @(negedge clock_i);
      if (got_n == n) begin mismatches++; end_sim(); end
      check(got, exp);
      // Eight idle cycles let the idle-time checks see a quiet chip select.
      repeat (8) @(negedge clock_i);
   endtask : frame

   task t_single;
      frame(cw(0, 4'h5, 0, 1, 1), 4'h0);
      cod = 1'b1;
      check({15'h0, span_one_ref_o}, 16'h0001);
      check({14'h0, power_mode_o}, 16'h0003);
      frame(16'h0000, 4'h5);
      frame(cw(0, 4'h9, 0, 0, 0), 4'h5);
      cod = 1'b0;
      check({15'h0, span_one_ref_o}, 16'h0000);
      frame(16'h7FF0, 4'h9);
      frame(16'h0000, 4'h9);
   endtask : t_single

   task t_pattern;
      frame(cw(0, 4'h9, 1, 0, 0), 4'h9);
      frame(16'h2480, 4'h9);
      frame(16'h0000, 4'h2);
      frame(16'h0000, 4'h5);
      frame(16'h0000, 4'h8);
      frame(16'h0000, 4'h2);
      frame(cw(1, 4'hC, 0, 0, 1), 4'h5);
      cod = 1'b1;
      frame(16'h0000, 4'h8);
      frame(cw(0, 4'h4, 0, 0, 1), 4'h2);
      frame(16'h0000, 4'h4);
   endtask : t_pattern

   task t_consec;
      frame(cw(1, 4'h2, 1, 0, 1), 4'h4);
      frame(16'h0000, 4'h0);
      frame(16'h0000, 4'h1);
      frame(16'h0000, 4'h2);
      frame(cw(1, 4'h2, 0, 0, 1), 4'h0);
      frame(16'h0000, 4'h1);
      frame(16'h0000, 4'h2);
      frame(16'h0000, 4'h0);
   endtask : t_consec

   initial begin
      clock_i = 1'b0;
      rst_i = 1'b1;
      mismatches = 0;
      checks_done = 0;
      got_n = 0;
      got = 16'h0000;
      cod = 1'b0;
      repeat (12) @(negedge clock_i);
      rst_i = 1'b0;
      repeat (2) @(negedge clock_i);
      t_single();
      t_pattern();
      t_consec();
      end_sim();
   end
endmodule : acs_top_bench
`default_nettype wire
